// ### design/cwr_div.sv
// Shared constants and the peripheral clock-enable divider
package cwr_pkg;
    localparam int NUM_DIV = 21;
    localparam int NUM_FRAC = 5;
    localparam int DIV_W = 16;
    localparam int FRAC_W = 5;
    localparam int WDT_W = 16;
    localparam int TRIM_W = 8;
    localparam int CAUSE_W = 5;
    localparam int IRQ_W = 32;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
    localparam int MAIN_OSC_HZ = 48000000;
    localparam int LP_OSC_HZ = 32000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_HOLD_NS = 100;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RST_HOLD_LOAD = 8'(RST_HOLD_CYC - 1);
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_SW = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_DROP = 4;
    typedef enum logic [1:0] {PM_BOOT, PM_ACTIVE, PM_SLEEP, PM_DEEP} cwr_pmode_t;
    typedef enum logic [1:0] {SW_RUN, SW_STOP, SW_START} cwr_sw_t;
endpackage

`timescale 1ns/1ps
module cwr_div #(
    parameter bit FRAC = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_hf_rise,
    input wire logic i_en,
    input wire logic [cwr_pkg::DIV_W-1:0] i_div_int,
    input wire logic [cwr_pkg::FRAC_W-1:0] i_div_frac,
    output logic o_pulse
);
    import cwr_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [FRAC_W-1:0] acc;
        logic pulse;
    } cwr_div_st_t;

    cwr_div_st_t st_reg;
    cwr_div_st_t st_next;
    logic [FRAC_W:0] sum;
    logic [DIV_W:0] per;

    // ----------------------------------------
    // One-in-N enable with optional fraction
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        sum = {1'b0, st_reg.acc} + {1'b0, (FRAC ? i_div_frac : {FRAC_W{1'b0}})};
        per = {1'b0, i_div_int} + {{DIV_W{1'b0}}, sum[FRAC_W]};
        if (!i_en) begin
            st_next.cnt = '0;
            st_next.acc = '0;
        end else if (i_hf_rise) begin
            if (st_reg.cnt == '0) begin
                st_next.pulse = 1'b1;
                st_next.acc = sum[FRAC_W-1:0];
                // New divisor only taken at the period boundary
                st_next.cnt = (per > 17'h1) ? DIV_W'(per - 17'h1) : '0;
            end else begin
                st_next.cnt = st_reg.cnt - 16'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_pulse = st_reg.pulse;
endmodule

// ### design/cwr_top.sv
// Clock select, dividers, watchdog, reset and power-mode control
//
// Functional notes
// - Source switch without glitches or runt pulses
// - Synchronise selection and divider control changes
// - Twenty-one dividers: five fractional, sixteen integer
// - All dividers run from high-frequency clock
// - Digital dividers give one-in-N enables
// - Analog clock leads the digital enables
// - Analog divider keeps 50% duty, odd too
// - Main oscillator primary, 48 MHz after reset
// - Trim from supervisory rows, later from flash
// - Low-power oscillator stays on in deep sleep
// - Watchdog counts on low-power oscillator
// - Unserviced watchdog timeout issues system reset
// - Watchdog may raise interrupt before reset
// - Several reset sources including software
// - Reset returns state to defined values
// - Sticky reset cause survives system reset
// - Dedicated external reset pin
// - Hold mode entry until supply good; drop resets
// - Active, sleep, deep-sleep sequenced here
// - Wakeup controller wakes from deep sleep
`timescale 1ns/1ps
module cwr_top (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_main_osc,
    input wire logic i_lp_osc,
    input wire logic i_clk_sel_lp,
    input wire logic [cwr_pkg::NUM_DIV-1:0] i_div_en,
    input wire logic [cwr_pkg::NUM_DIV-1:0][cwr_pkg::DIV_W-1:0] i_div_int,
    input wire logic [cwr_pkg::NUM_FRAC-1:0][cwr_pkg::FRAC_W-1:0] i_div_frac,
    input wire logic [cwr_pkg::DIV_W-1:0] i_ana_div,
    input wire logic i_trim_nv_valid,
    input wire logic [cwr_pkg::TRIM_W-1:0] i_trim_nv,
    input wire logic i_trim_flash_wr,
    input wire logic [cwr_pkg::TRIM_W-1:0] i_trim_flash,
    input wire logic i_wdt_en,
    input wire logic i_wdt_service,
    input wire logic [cwr_pkg::WDT_W-1:0] i_wdt_limit,
    input wire logic i_wdt_irq_en,
    input wire logic i_wdt_irq_clear,
    input wire logic i_external_reset_pin_n,
    input wire logic i_sw_reset_req,
    input wire logic i_supply_ok,
    input wire logic i_supply_drop_detect,
    input wire logic i_cause_clear,
    input wire logic i_sleep_req,
    input wire logic i_deep_sleep_req,
    input wire logic [cwr_pkg::IRQ_W-1:0] i_irq_req,
    input wire logic [cwr_pkg::IRQ_W-1:0] i_wake_irq_en,
    output logic o_hf_clk,
    output logic o_clk_src_lp,
    output logic o_main_osc_on,
    output logic [cwr_pkg::TRIM_W-1:0] o_osc_trim,
    output logic [cwr_pkg::NUM_DIV-1:0] o_per_clk_en,
    output logic o_ana_clk,
    output logic o_lp_clk_on,
    output logic o_wdt_irq,
    output logic o_sys_reset,
    output logic [cwr_pkg::CAUSE_W-1:0] o_reset_cause,
    output cwr_pkg::cwr_pmode_t o_power_mode,
    output logic o_cpu_clk_on
);
    import cwr_pkg::*;

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic pin_s1;
        logic pin_s2;
        logic sel_lp;
        cwr_sw_t sw;
        logic hf_lvl;
        logic hf_prev;
        logic [NUM_DIV-1:0] per_en;
        logic ana_lvl;
        logic [DIV_W-1:0] ana_cnt;
        logic [DIV_W-1:0] ana_edges;
        logic lp_prev;
        logic lp_on;
        logic [WDT_W-1:0] wdt_cnt;
        logic wdt_warned;
        logic wdt_irq;
        logic sys_rst;
        logic [7:0] rst_cnt;
        logic [CAUSE_W-1:0] cause;
        cwr_pmode_t mode;
        logic osc_on;
        logic cpu_on;
        logic trim_done;
        logic [TRIM_W-1:0] trim;
    } cwr_top_st_t;

    localparam cwr_top_st_t ST_RESET = '{
        sel_s1: 1'b0, sel_s2: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1, sel_lp: 1'b0,
        sw: SW_RUN, hf_lvl: 1'b0, hf_prev: 1'b0, per_en: '0, ana_lvl: 1'b0,
        ana_cnt: '0, ana_edges: '0, lp_prev: 1'b0, lp_on: 1'b1, wdt_cnt: '0,
        wdt_warned: 1'b0, wdt_irq: 1'b0, sys_rst: 1'b1, rst_cnt: RST_HOLD_LOAD,
        cause: CAUSE_W'(1) << CAUSE_POR, mode: PM_BOOT, osc_on: 1'b1, cpu_on: 1'b0,
        trim_done: 1'b0, trim: TRIM_RESET};

    cwr_top_st_t st_reg;
    cwr_top_st_t st_next;
    logic hf_rise;
    logic hf_edge;
    logic lp_rise;
    logic cur_src;
    logic wake;
    logic wdt_to;
    logic [CAUSE_W-1:0] rst_src;
    logic [NUM_DIV-1:0] dig_pulse;
    logic [NUM_DIV-1:0][FRAC_W-1:0] dfrac;

    assign hf_rise = st_reg.hf_lvl & ~st_reg.hf_prev;
    assign hf_edge = st_reg.hf_lvl ^ st_reg.hf_prev;
    assign lp_rise = i_lp_osc & ~st_reg.lp_prev;
    assign wake = |(i_irq_req & i_wake_irq_en);

    // ----------------------------------------
    // Peripheral dividers
    // ----------------------------------------
    genvar k;
    generate
        for (k = 0; k < NUM_DIV; k++) begin : g_div
            if (k < NUM_FRAC) begin : g_frac
                assign dfrac[k] = i_div_frac[k];
            end else begin : g_int
                assign dfrac[k] = '0;
            end
            cwr_div #(.FRAC(k < NUM_FRAC)) u_div (
                .i_clk(i_clk),
                .i_srst(i_srst),
                .i_hf_rise(hf_rise),
                .i_en(i_div_en[k]),
                .i_div_int(i_div_int[k]),
                .i_div_frac(dfrac[k]),
                .o_pulse(dig_pulse[k])
            );
        end
    endgenerate

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        wdt_to = 1'b0;
        st_next.sel_s1 = i_clk_sel_lp;
        st_next.sel_s2 = st_reg.sel_s1;
        st_next.pin_s1 = i_external_reset_pin_n;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.hf_prev = st_reg.hf_lvl;
        st_next.lp_prev = i_lp_osc;
        st_next.lp_on = 1'b1;
        st_next.per_en = dig_pulse;

        // Glitch-free source switch: gate while low, restart from low
        cur_src = st_reg.sel_lp ? i_lp_osc : (i_main_osc & (st_reg.osc_on | st_reg.hf_lvl));
        unique case (st_reg.sw)
            SW_RUN: begin
                st_next.hf_lvl = cur_src;
                if (st_reg.sel_s2 != st_reg.sel_lp) begin
                    st_next.sw = SW_STOP;
                end
            end
            SW_STOP: begin
                st_next.hf_lvl = cur_src & st_reg.hf_lvl;
                if (!cur_src) begin
                    st_next.sel_lp = st_reg.sel_s2;
                    st_next.sw = SW_START;
                end
            end
            SW_START: begin
                st_next.hf_lvl = 1'b0;
                if (!cur_src) begin
                    st_next.sw = SW_RUN;
                end
            end
            default: begin
                st_next.hf_lvl = 1'b0;
                st_next.sw = SW_RUN;
            end
        endcase

        // Analog clock toggles every N half periods
        if (i_ana_div == '0) begin
            st_next.ana_cnt = '0;
        end else if (hf_edge) begin
            if (st_reg.ana_cnt >= i_ana_div - 16'h1) begin
                st_next.ana_lvl = ~st_reg.ana_lvl;
                st_next.ana_cnt = '0;
            end else begin
                st_next.ana_cnt = st_reg.ana_cnt + 16'h1;
            end
        end
        if (i_ana_div == '0 || st_next.ana_lvl != st_reg.ana_lvl) begin
            st_next.ana_edges = '0;
        end else if (hf_edge) begin
            st_next.ana_edges = st_reg.ana_edges + 16'h1;
        end

        // Trim load
        if (!st_reg.trim_done && i_trim_nv_valid) begin
            st_next.trim = i_trim_nv;
            st_next.trim_done = 1'b1;
        end else if (st_reg.trim_done && i_trim_flash_wr) begin
            st_next.trim = i_trim_flash;
        end

        // Watchdog
        if (!i_wdt_en || i_wdt_service) begin
            st_next.wdt_cnt = '0;
            st_next.wdt_warned = 1'b0;
        end else if (lp_rise) begin
            if (st_reg.wdt_cnt == i_wdt_limit) begin
                st_next.wdt_cnt = '0;
                if (i_wdt_irq_en && !st_reg.wdt_warned) begin
                    st_next.wdt_warned = 1'b1;
                end else begin
                    wdt_to = 1'b1;
                end
            end else begin
                st_next.wdt_cnt = st_reg.wdt_cnt + 16'h1;
            end
        end
        st_next.wdt_irq = (st_reg.wdt_irq & ~i_wdt_irq_clear) |
            (st_next.wdt_warned & ~st_reg.wdt_warned);

        // Reset sources and sticky cause
        rst_src = '0;
        rst_src[CAUSE_PIN] = ~st_reg.pin_s2;
        rst_src[CAUSE_SW] = i_sw_reset_req;
        rst_src[CAUSE_WDT] = wdt_to;
        rst_src[CAUSE_DROP] = i_supply_drop_detect;
        st_next.cause = (i_cause_clear ? '0 : st_reg.cause) | rst_src;
        if (|rst_src) begin
            st_next.sys_rst = 1'b1;
            st_next.rst_cnt = RST_HOLD_LOAD;
        end else if (st_reg.rst_cnt != '0) begin
            st_next.rst_cnt = st_reg.rst_cnt - 8'h1;
        end else begin
            st_next.sys_rst = 1'b0;
        end

        // Power modes
        unique case (st_reg.mode)
            PM_BOOT: begin
                st_next.osc_on = 1'b1;
                if (i_supply_ok && st_reg.trim_done && !st_reg.sys_rst) begin
                    st_next.mode = PM_ACTIVE;
                end
            end
            PM_ACTIVE: begin
                if (i_deep_sleep_req) begin
                    st_next.mode = PM_DEEP;
                    st_next.osc_on = 1'b0;
                end else if (i_sleep_req) begin
                    st_next.mode = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (wake) begin
                    st_next.mode = PM_ACTIVE;
                end
            end
            PM_DEEP: begin
                if (wake) begin
                    st_next.mode = PM_ACTIVE;
                    st_next.osc_on = 1'b1;
                end
            end
        endcase
        if (st_next.sys_rst || !i_supply_ok) begin
            st_next.mode = PM_BOOT;
            st_next.osc_on = 1'b1;
            st_next.wdt_cnt = '0;
            st_next.wdt_warned = 1'b0;
            st_next.wdt_irq = 1'b0;
        end
        st_next.cpu_on = (st_next.mode == PM_ACTIVE);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_hf_clk = st_reg.hf_lvl;
    assign o_clk_src_lp = st_reg.sel_lp;
    assign o_main_osc_on = st_reg.osc_on;
    assign o_osc_trim = st_reg.trim;
    assign o_per_clk_en = st_reg.per_en;
    assign o_ana_clk = st_reg.ana_lvl;
    assign o_lp_clk_on = st_reg.lp_on;
    assign o_wdt_irq = st_reg.wdt_irq;
    assign o_sys_reset = st_reg.sys_rst;
    assign o_reset_cause = st_reg.cause;
    assign o_power_mode = st_reg.mode;
    assign o_cpu_clk_on = st_reg.cpu_on;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_hf_from_src: assert property ($rose(st_reg.hf_lvl) |-> $past(st_reg.sw) == SW_RUN)
        else $error("hf clock rose outside run state");
    a_sel_sync: assert property ($changed(st_reg.sel_s2) |-> st_reg.sel_s2 == $past(i_clk_sel_lp, 2))
        else $error("selection not taken through two stages");
    a_per_from_hf: assert property (o_per_clk_en[0] |-> $past(hf_rise, 2))
        else $error("peripheral enable without hf rise");
    a_per_one_in_n: assert property (o_per_clk_en[NUM_FRAC] && i_div_int[NUM_FRAC] > 16'h1 &&
        $stable(i_div_int[NUM_FRAC]) |=> !o_per_clk_en[NUM_FRAC])
        else $error("integer enable lasted more than one cycle");
    a_ana_on_edge: assert property ($changed(o_ana_clk) |-> $past(hf_edge))
        else $error("analog clock moved without hf edge");
    a_ana_duty: assert property ($changed(o_ana_clk) && $stable(i_ana_div) && $past(o_ana_clk, 2) == $past(o_ana_clk)
        && i_ana_div != '0 |-> $past(st_reg.ana_edges) == i_ana_div - 16'h1)
        else $error("analog half period not N edges");
    a_lp_deep: assert property (o_power_mode == PM_DEEP |-> o_lp_clk_on && !o_main_osc_on)
        else $error("deep sleep clocks wrong");
    a_wdt_reset: assert property (wdt_to |=> o_sys_reset && o_reset_cause[CAUSE_WDT])
        else $error("watchdog timeout gave no reset");
    a_wdt_irq_first: assert property (lp_rise && i_wdt_en && !i_wdt_service && i_wdt_irq_en &&
        !st_reg.wdt_warned && st_reg.wdt_cnt == i_wdt_limit |=> !o_sys_reset [*1] or o_wdt_irq)
        else $error("watchdog interrupt not raised ahead");
    a_rst_hold: assert property ($rose(o_sys_reset) |-> o_sys_reset [*8])
        else $error("system reset too short");
    a_cause_sticky: assert property (!i_cause_clear |=> ($past(o_reset_cause) & ~o_reset_cause) == '0)
        else $error("reset cause lost");
    a_pin_reset: assert property (!i_external_reset_pin_n [*3] |=> o_sys_reset)
        else $error("reset pin ignored");
    a_supply_hold: assert property (!i_supply_ok |=> o_power_mode == PM_BOOT)
        else $error("mode entered without good supply");
    a_deep_wake: assert property (o_power_mode == PM_DEEP && wake && !o_sys_reset && i_supply_ok &&
        !i_supply_drop_detect && !i_sw_reset_req && st_reg.pin_s2 && !wdt_to |=> o_power_mode == PM_ACTIVE)
        else $error("no wake from deep sleep");

    c_switch_lp: cover property ($rose(o_clk_src_lp));
    c_deep_wake: cover property (o_power_mode == PM_DEEP ##1 o_power_mode == PM_ACTIVE);
    c_wdt_irq: cover property ($rose(o_wdt_irq));
    c_frac_pulse: cover property (o_per_clk_en[0] && i_div_frac[0] != '0);
endmodule

// ### sim/cwr_osc_model.sv
// Model of the two oscillators that feed the clock block
`timescale 1ns/1ps
module cwr_osc_model #(
    parameter int MAIN_H = 2,
    parameter int LP_H = 20
) (
    input wire logic i_clk,
    input wire logic i_main_osc_on,
    output logic o_main_osc = 1'b0,
    output logic o_lp_osc = 1'b0
);
    int main_cnt = 0;
    int lp_cnt = 0;
    // ----------------------------------------
    // Sources
    // ----------------------------------------
    // Main source finishes its high phase, then stops low while disabled
    always @(negedge i_clk) begin
        if (o_main_osc || i_main_osc_on) begin
            main_cnt++;
            if (main_cnt == MAIN_H) begin
                o_main_osc <= ~o_main_osc;
                main_cnt = 0;
            end
        end
    end
    // Low-power source runs free in every mode
    always @(negedge i_clk) begin
        lp_cnt++;
        if (lp_cnt == LP_H) begin
            o_lp_osc <= ~o_lp_osc;
            lp_cnt = 0;
        end
    end
endmodule

// ### sim/clock_watchdog_reset_system_test.sv
// Self-checking bench for clock select, dividers, watchdog and reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module clock_watchdog_reset_system_test;
    import cwr_pkg::*;
    localparam int MAIN_H = 2;
    localparam int LP_H = 20;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_main_osc;
    logic i_lp_osc;
    logic i_clk_sel_lp = 1'b0;
    logic [NUM_DIV-1:0] i_div_en = '0;
    logic [NUM_DIV-1:0][DIV_W-1:0] i_div_int = '0;
    logic [NUM_FRAC-1:0][FRAC_W-1:0] i_div_frac = '0;
    logic [DIV_W-1:0] i_ana_div = '0;
    logic i_trim_nv_valid = 1'b0;
    logic [TRIM_W-1:0] i_trim_nv = '0;
    logic i_trim_flash_wr = 1'b0;
    logic [TRIM_W-1:0] i_trim_flash = '0;
    logic i_wdt_en = 1'b0;
    logic i_wdt_service = 1'b0;
    logic [WDT_W-1:0] i_wdt_limit = '0;
    logic i_wdt_irq_en = 1'b0;
    logic i_wdt_irq_clear = 1'b0;
    logic i_external_reset_pin_n = 1'b1;
    logic i_sw_reset_req = 1'b0;
    logic i_supply_ok = 1'b0;
    logic i_supply_drop_detect = 1'b0;
    logic i_cause_clear = 1'b0;
    logic i_sleep_req = 1'b0;
    logic i_deep_sleep_req = 1'b0;
    logic [IRQ_W-1:0] i_irq_req = '0;
    logic [IRQ_W-1:0] i_wake_irq_en = '0;
    logic o_hf_clk;
    logic o_clk_src_lp;
    logic o_main_osc_on;
    logic [TRIM_W-1:0] o_osc_trim;
    logic [NUM_DIV-1:0] o_per_clk_en;
    logic o_ana_clk;
    logic o_lp_clk_on;
    logic o_wdt_irq;
    logic o_sys_reset;
    logic [CAUSE_W-1:0] o_reset_cause;
    cwr_pmode_t o_power_mode;
    logic o_cpu_clk_on;
    int mismatches = 0;
    int n_tests = 0;
    int exp_q[$];
    int ana_q[$];
    int mon_k = 0;
    int mon_span = 1;
    int mon_p = 0;
    int mon_t = 0;
    int mon_e;
    int ana_t = 0;
    int ana_e;
    int hf_t = 0;
    int hf_hi = 0;
    int src_b[3] = '{CAUSE_PIN, CAUSE_SW, CAUSE_DROP};
    logic mon_go = 1'b0;
    logic ana_go = 1'b0;
    logic ana_arm = 1'b0;
    logic ana_last = 1'b0;
    logic hf_last = 1'b0;

    cwr_top dut_u (.*);
    cwr_osc_model #(.MAIN_H(MAIN_H), .LP_H(LP_H)) osc_u (.i_clk(i_clk), .i_main_osc_on(o_main_osc_on),
        .o_main_osc(i_main_osc), .o_lp_osc(i_lp_osc));

    always #2.5 i_clk = ~i_clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wait_for(input string nm, ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            cyc(1);
            k++;
        end
        `CHK(nm, v, s)
    endtask
    task automatic wait_mode(input cwr_pmode_t m, input int lim);
        int k;
        k = 0;
        while (o_power_mode !== m && k < lim) begin
            cyc(1);
            k++;
        end
        `CHK("mode", m, o_power_mode)
    endtask
    task automatic drain(ref int q[$], input int lim);
        int k;
        k = 0;
        while (q.size() > 0 && k < lim) begin
            cyc(1);
            k++;
        end
        `CHK("drained", 0, q.size())
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Output watchers
    // ----------------------------------------
    always @(posedge i_clk) begin
        mon_t++;
        if (!mon_go) mon_p = 0;
        else if (o_per_clk_en[mon_k] === 1'b1) begin
            if (mon_p == 0 || mon_p == mon_span) begin
                if (mon_p == mon_span && exp_q.size() > 0) begin
                    mon_e = exp_q.pop_front();
                    `CHK("div_gap", mon_e, mon_t)
                end
                mon_t = 0;
                mon_p = 0;
            end
            mon_p++;
            `CHK("div_other", 21'h0, o_per_clk_en & ~(21'h1 << mon_k))
        end
    end
    always @(posedge i_clk) begin
        ana_t++;
        if (!ana_go) ana_arm = 1'b0;
        if (ana_go && i_div_en[5] && o_per_clk_en[5] === 1'b1) `CHK("ana_lead", 1, ana_t)
        if (o_ana_clk !== ana_last) begin
            if (ana_arm && ana_q.size() > 0) begin
                ana_e = ana_q.pop_front();
                `CHK("ana_half", ana_e, ana_t)
            end
            ana_arm = ana_go;
            ana_t = 0;
            ana_last = o_ana_clk;
        end
    end
    always @(posedge i_clk) begin
        if (o_hf_clk === hf_last) hf_t++;
        else begin
            if (hf_last === 1'b1) `CHK("hf_high", 1'b1, hf_t == MAIN_H || hf_t == LP_H)
            if (hf_last === 1'b1) hf_hi = hf_t;
            hf_t = 1;
            hf_last = o_hf_clk;
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9d721f61));
        cyc(8);
        i_srst = 1'b0;
        `CHK("cause", 5'h01, o_reset_cause)
        `CHK("trim", TRIM_RESET, o_osc_trim)
        `CHK("lp_on", 1'b1, o_lp_clk_on)
        `CHK("src_main", 1'b0, o_clk_src_lp)
        cyc(18);
        `CHK("rst_hold", 1'b1, o_sys_reset)
        cyc(26);
        `CHK("rst_end", 1'b0, o_sys_reset)
        `CHK("boot_hold", PM_BOOT, o_power_mode)
        i_trim_nv = TRIM_W'($urandom());
        i_trim_nv_valid = 1'b1;
        i_supply_ok = 1'b1;
        wait_mode(PM_ACTIVE, 50);
        `CHK("trim_nv", i_trim_nv, o_osc_trim)
        i_trim_flash = ~i_trim_nv;
        pulse(i_trim_flash_wr);
        cyc(3);
        `CHK("trim_fl", i_trim_flash, o_osc_trim)
        i_clk_sel_lp = 1'b1;
        wait_for("to_lp", o_clk_src_lp, 1'b1, 4 * LP_H);
        cyc(6 * LP_H);
        `CHK("lp_run", LP_H, hf_hi)
        i_clk_sel_lp = 1'b0;
        wait_for("to_main", o_clk_src_lp, 1'b0, 4 * LP_H);
        cyc(20);
        `CHK("main_run", MAIN_H, hf_hi)
        for (int k = 0; k < NUM_DIV; k++) begin
            int n;
            int f;
            n = $urandom_range(4, k < NUM_FRAC ? 1 : 0);
            f = k < NUM_FRAC ? $urandom_range(31, 1) : 0;
            i_div_int[k] = DIV_W'(n);
            if (k < NUM_FRAC) i_div_frac[k] = FRAC_W'(f);
            mon_k = k;
            mon_span = k < NUM_FRAC ? 32 : 1;
            repeat (k < NUM_FRAC ? 2 : 3) exp_q.push_back(((n < 1 ? 1 : n) * mon_span + f) * 2 * MAIN_H);
            mon_go = 1'b1;
            i_div_en[k] = 1'b1;
            drain(exp_q, 6000);
            i_div_en[k] = 1'b0;
            mon_go = 1'b0;
            cyc(6);
        end
        i_div_int[5] = 16'h1;
        for (int j = 0; j < 3; j++) begin
            int n;
            n = j == 2 ? 1 : 2 * $urandom_range(3, 1) + j;
            repeat (4) ana_q.push_back(n * MAIN_H);
            i_ana_div = DIV_W'(n);
            ana_go = 1'b1;
            cyc(10);
            i_div_en[5] = (j == 2);
            drain(ana_q, 500);
            ana_go = 1'b0;
            i_ana_div = '0;
            i_div_en[5] = 1'b0;
            cyc(20);
        end
        pulse(i_sleep_req);
        cyc(1);
        `CHK("sleep", PM_SLEEP, o_power_mode)
        `CHK("cpu_off", 1'b0, o_cpu_clk_on)
        i_wake_irq_en = 32'h1 << $urandom_range(31, 0);
        i_irq_req = ~i_wake_irq_en;
        cyc(3);
        `CHK("no_wake", PM_SLEEP, o_power_mode)
        i_irq_req = i_wake_irq_en;
        cyc(2);
        `CHK("wake", PM_ACTIVE, o_power_mode)
        `CHK("cpu_on", 1'b1, o_cpu_clk_on)
        i_irq_req = '0;
        i_deep_sleep_req = 1'b1;
        i_sleep_req = 1'b1;
        cyc(1);
        i_deep_sleep_req = 1'b0;
        i_sleep_req = 1'b0;
        cyc(1);
        `CHK("deep", PM_DEEP, o_power_mode)
        `CHK("osc_off", 1'b0, o_main_osc_on)
        `CHK("lp_deep", 1'b1, o_lp_clk_on)
        i_irq_req = i_wake_irq_en;
        cyc(2);
        `CHK("deep_wake", PM_ACTIVE, o_power_mode)
        i_irq_req = '0;
        i_supply_ok = 1'b0;
        cyc(2);
        `CHK("supply_low", PM_BOOT, o_power_mode)
        i_supply_ok = 1'b1;
        wait_mode(PM_ACTIVE, 10);
        pulse(i_cause_clear);
        i_wdt_limit = 16'h3;
        i_wdt_irq_en = 1'b1;
        i_wdt_en = 1'b1;
        repeat (12) begin
            cyc(2 * LP_H);
            pulse(i_wdt_service);
        end
        `CHK("wdt_quiet", 1'b0, o_wdt_irq | o_sys_reset)
        wait_for("wdt_irq", o_wdt_irq, 1'b1, 16 * LP_H);
        `CHK("irq_first", 1'b0, o_sys_reset)
        pulse(i_wdt_irq_clear);
        cyc(2);
        `CHK("irq_clr", 1'b0, o_wdt_irq)
        wait_for("wdt_rst", o_sys_reset, 1'b1, 16 * LP_H);
        i_wdt_en = 1'b0;
        `CHK("wdt_mode", PM_BOOT, o_power_mode)
        wait_for("wdt_end", o_sys_reset, 1'b0, 60);
        `CHK("wdt_cause", 5'h08, o_reset_cause)
        for (int j = 0; j < 3; j++) begin
            pulse(i_cause_clear);
            i_external_reset_pin_n = (j != 0);
            i_sw_reset_req = (j == 1);
            i_supply_drop_detect = (j == 2);
            cyc(4);
            `CHK("src_rst", 1'b1, o_sys_reset)
            `CHK("rst_mode", PM_BOOT, o_power_mode)
            i_external_reset_pin_n = 1'b1;
            i_sw_reset_req = 1'b0;
            i_supply_drop_detect = 1'b0;
            wait_for("src_end", o_sys_reset, 1'b0, 60);
            `CHK("src_cause", CAUSE_W'(1 << src_b[j]), o_reset_cause)
        end
        conclude();
    end

    // Limit well above the roughly 6000 cycles the sequence needs
    initial begin
        #300000;
        mismatches++;
        conclude();
    end
endmodule
